// [verilog/refclk_sw_cfg.svh]
`ifndef REFCLK_SW_CFG_SVH
`define REFCLK_SW_CFG_SVH

`define CLK_PERIOD_NS 4
`define REF_PERIOD_NS 40
`define REF_HALF_CYCLES ((`REF_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define LOSS_PERIODS 2
`define LOSS_CYCLES ((`LOSS_PERIODS * `REF_PERIOD_NS) / `CLK_PERIOD_NS)
`define REQ_HOLD_PERIODS 3
`define RESET_PULSE_NS 10
`define RESET_PULSE_CYCLES \
   ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_EDGES 8
`define LOCK_STABLE_CYCLES 16
`define DRIFT_CYCLES 64
`define CNT_W 8
`define OSC_W 8
`define OSC_NOMINAL 8'h80
`define OSC_FLOOR 8'h00
`define SEL_PRIMARY 1'b0
`define SEL_BACKUP 1'b1

`endif

// [verilog/refclk_sw_pkg.sv]
package refclk_sw_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_GATE = 2'b01,
      ST_JOIN = 2'b10
   } sw_state_type;
   typedef enum logic [1:0] {
      U_IDLE = 2'b00,
      U_HOLD = 2'b01,
      U_WAIT = 2'b10,
      U_RST = 2'b11
   } user_state_type;
endpackage

// [verilog/refclk_sw_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface refclk_sw_if;
   logic primaryRefClk;
   logic backupRefClk;
   logic switchReq;
   logic manualOnly;
   logic pllReset;
   logic pfdEna;
   logic [1:0] clkBad;
   logic activeClock;
   logic locked;
   modport device (
      input primaryRefClk, backupRefClk, switchReq, manualOnly,
      input pllReset, pfdEna,
      output clkBad, activeClock, locked
   );
   modport user (
      output primaryRefClk, backupRefClk, switchReq, manualOnly,
      output pllReset, pfdEna,
      input clkBad, activeClock, locked
   );
endinterface
`default_nettype wire

// [verilog/clock_sense.sv]
`timescale 1ns/100ps
`default_nettype none
`include "refclk_sw_cfg.svh"
module clock_sense #(
   parameter int LOSS_CYCLES = `LOSS_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic refLvl,
   output logic rise,
   output logic fall,
   output logic bad
);
   logic prev_r;
   logic bad_r;
   logic [`CNT_W-1:0] idle_r;
   logic [`CNT_W-1:0] lossLimit;

   assign lossLimit = `CNT_W'(LOSS_CYCLES - 1);
   assign rise = refLvl & ~prev_r;
   assign fall = ~refLvl & prev_r;
   assign bad = bad_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_r <= 1'b0;
         idle_r <= '0;
         bad_r <= 1'b0;
      end else begin
         prev_r <= refLvl;
         if (rise) begin
            idle_r <= '0;
            bad_r <= 1'b0;
         end else if (idle_r == lossLimit) begin
            bad_r <= 1'b1;
         end else begin
            idle_r <= idle_r + `CNT_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/refclk_switchover.sv]
`timescale 1ns/100ps
`default_nettype none
`include "refclk_sw_cfg.svh"
module refclk_switchover #(
   parameter int LOSS_CYCLES = `LOSS_CYCLES,
   parameter int LOCK_EDGES = `LOCK_EDGES,
   parameter int DRIFT_CYCLES = `DRIFT_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   refclk_sw_if.device link,
   output logic gatedRef,
   output logic [`OSC_W-1:0] oscCtrl,
   output logic switching
);
   // Reference pins are asynchronous to clk
   logic pSync1_r;
   logic pSync2_r;
   logic bSync1_r;
   logic bSync2_r;
   logic reqPrev_r;
   logic sel_r;
   logic gateOn_r;
   logic gatedRef_r;
   logic locked_r;
   logic switching_r;
   logic [`OSC_W-1:0] osc_r;
   logic [`OSC_W-1:0] osc_nxt;
   logic [`CNT_W-1:0] lockCnt_r;
   logic [`CNT_W-1:0] driftCnt_r;
   refclk_sw_pkg::sw_state_type state_r;
   refclk_sw_pkg::sw_state_type state_nxt;

   logic pRise;
   logic pFall;
   logic pBad;
   logic bRise;
   logic bFall;
   logic bBad;

   clock_sense #(.LOSS_CYCLES(LOSS_CYCLES)) u_primarySense (
      .clk(clk),
      .arst_n(arst_n),
      .refLvl(pSync2_r),
      .rise(pRise),
      .fall(pFall),
      .bad(pBad)
   );

   clock_sense #(.LOSS_CYCLES(LOSS_CYCLES)) u_backupSense (
      .clk(clk),
      .arst_n(arst_n),
      .refLvl(bSync2_r),
      .rise(bRise),
      .fall(bFall),
      .bad(bBad)
   );

   function automatic logic pick(input logic s, input logic p,
                                 input logic b);
      pick = s ? b : p;
   endfunction

   wire reqRise = link.switchReq & ~reqPrev_r;
   wire actBad = pick(sel_r, pBad, bBad);
   wire othBad = pick(sel_r, bBad, pBad);
   wire oldFall = pick(sel_r, pFall, bFall);
   wire newFall = pick(sel_r, bFall, pFall);
   wire actLvl = pick(sel_r, pSync2_r, bSync2_r);
   wire actRise = pick(sel_r, pRise, bRise);
   // Manual-only mode ignores loss; request edges still act
   wire autoGo = ~link.manualOnly & actBad;
   wire startSw = reqRise | autoGo;
   wire gateNow = oldFall | actBad;
   // A dead target never yields a falling edge, so we wait here
   wire joinNow = newFall & ~othBad;
   wire lockLimit = lockCnt_r == `CNT_W'(LOCK_EDGES - 1);
   wire driftTick = driftCnt_r == `CNT_W'(DRIFT_CYCLES - 1);
   wire oscAtNom = osc_r == `OSC_NOMINAL;
   wire loopLive = link.pfdEna & gateOn_r & ~actBad;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         refclk_sw_pkg::ST_RUN: begin
            if (startSw) begin
               state_nxt = refclk_sw_pkg::ST_GATE;
            end
         end
         refclk_sw_pkg::ST_GATE: begin
            if (gateNow) begin
               state_nxt = refclk_sw_pkg::ST_JOIN;
            end
         end
         refclk_sw_pkg::ST_JOIN: begin
            if (joinNow) begin
               state_nxt = refclk_sw_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = refclk_sw_pkg::ST_RUN;
         end
      endcase
   end

   always_comb begin
      osc_nxt = osc_r;
      if (link.pllReset) begin
         osc_nxt = `OSC_NOMINAL;
      end else if (loopLive) begin
         if (osc_r < `OSC_NOMINAL) begin
            osc_nxt = osc_r + `OSC_W'(1);
         end else if (osc_r > `OSC_NOMINAL) begin
            osc_nxt = osc_r - `OSC_W'(1);
         end
      end else if (driftTick && osc_r != `OSC_FLOOR) begin
         // Held control only sags slowly downward
         osc_nxt = osc_r - `OSC_W'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pSync1_r <= 1'b0;
         pSync2_r <= 1'b0;
         bSync1_r <= 1'b0;
         bSync2_r <= 1'b0;
         reqPrev_r <= 1'b0;
      end else begin
         pSync1_r <= link.primaryRefClk;
         pSync2_r <= pSync1_r;
         bSync1_r <= link.backupRefClk;
         bSync2_r <= bSync1_r;
         reqPrev_r <= link.switchReq;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= refclk_sw_pkg::ST_RUN;
         sel_r <= `SEL_PRIMARY;
         gateOn_r <= 1'b1;
         switching_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         switching_r <= state_nxt != refclk_sw_pkg::ST_RUN;
         if (state_r == refclk_sw_pkg::ST_GATE && gateNow) begin
            gateOn_r <= 1'b0;
         end
         if (state_r == refclk_sw_pkg::ST_JOIN && joinNow) begin
            // Repeats each time, either direction
            sel_r <= ~sel_r;
            gateOn_r <= 1'b1;
         end
      end
   end

   // Gated reference: old input low when cut, new low when joined
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gatedRef_r <= 1'b0;
      end else begin
         gatedRef_r <= gateOn_r & actLvl & ~link.pllReset;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_r <= `OSC_NOMINAL;
         driftCnt_r <= '0;
      end else begin
         osc_r <= osc_nxt;
         if (loopLive || link.pllReset || driftTick) begin
            driftCnt_r <= '0;
         end else begin
            driftCnt_r <= driftCnt_r + `CNT_W'(1);
         end
      end
   end

   // Lock needs settled control and a run of clean reference edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lockCnt_r <= '0;
         locked_r <= 1'b0;
      end else if (link.pllReset || !loopLive || !oscAtNom ||
                   state_r != refclk_sw_pkg::ST_RUN) begin
         lockCnt_r <= '0;
         locked_r <= 1'b0;
      end else if (actRise && !locked_r) begin
         if (lockLimit) begin
            locked_r <= 1'b1;
         end else begin
            lockCnt_r <= lockCnt_r + `CNT_W'(1);
         end
      end
   end

   // Flags come straight from the detectors; a running clock keeps them low
   assign link.clkBad = {bBad, pBad};
   assign link.activeClock = sel_r;
   assign link.locked = locked_r;
   assign gatedRef = gatedRef_r;
   assign oscCtrl = osc_r;
   assign switching = switching_r;
endmodule
`default_nettype wire

// [verilog/switch_user_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "refclk_sw_cfg.svh"
module switch_user_ctrl #(
   parameter int PRIM_HALF = `REF_HALF_CYCLES,
   parameter int BACK_HALF = `REF_HALF_CYCLES,
   parameter int LOCK_STABLE = `LOCK_STABLE_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   refclk_sw_if.user link,
   input wire logic primaryRun,
   input wire logic backupRun,
   input wire logic switchCmd,
   input wire logic keepPhase,
   input wire logic manualOnlyCfg,
   output logic outClkEna,
   output logic busy
);
   localparam int SLOW_HALF = (PRIM_HALF > BACK_HALF) ? PRIM_HALF
                                                      : BACK_HALF;
   localparam int HOLD_CYCLES = 2 * SLOW_HALF * `REQ_HOLD_PERIODS;

   logic [`CNT_W-1:0] pDiv_r;
   logic [`CNT_W-1:0] bDiv_r;
   logic pRef_r;
   logic bRef_r;
   logic [`CNT_W-1:0] cnt_r;
   logic [`CNT_W-1:0] stable_r;
   logic req_r;
   logic rst_r;
   logic pfd_r;
   logic mode_r;
   logic ena_r;
   logic busy_r;
   logic startSel_r;
   logic lastActive_r;
   refclk_sw_pkg::user_state_type state_r;

   function automatic logic at(input logic [`CNT_W-1:0] c, input int n);
      at = c == `CNT_W'(n - 1);
   endfunction

   wire bothRun = primaryRun & backupRun;
   wire autoMoved = link.activeClock != lastActive_r;
   wire anyBad = |link.clkBad;

   // Stopped sources park low, as a dead oscillator would
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pDiv_r <= '0;
         bDiv_r <= '0;
         pRef_r <= 1'b0;
         bRef_r <= 1'b0;
      end else begin
         pDiv_r <= at(pDiv_r, PRIM_HALF) ? '0 : pDiv_r + `CNT_W'(1);
         bDiv_r <= at(bDiv_r, BACK_HALF) ? '0 : bDiv_r + `CNT_W'(1);
         if (at(pDiv_r, PRIM_HALF)) begin
            pRef_r <= primaryRun & ~pRef_r;
         end
         if (at(bDiv_r, BACK_HALF)) begin
            bRef_r <= backupRun & ~bRef_r;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= refclk_sw_pkg::U_IDLE;
         cnt_r <= '0;
         req_r <= 1'b0;
         rst_r <= 1'b0;
         busy_r <= 1'b0;
         startSel_r <= `SEL_PRIMARY;
         lastActive_r <= `SEL_PRIMARY;
      end else begin
         lastActive_r <= link.activeClock;
         unique case (state_r)
            refclk_sw_pkg::U_IDLE: begin
               cnt_r <= '0;
               if (switchCmd && bothRun) begin
                  state_r <= refclk_sw_pkg::U_HOLD;
                  req_r <= 1'b1;
                  busy_r <= 1'b1;
                  startSel_r <= link.activeClock;
               end else if (autoMoved && keepPhase) begin
                  state_r <= refclk_sw_pkg::U_RST;
                  rst_r <= 1'b1;
                  busy_r <= 1'b1;
               end
            end
            refclk_sw_pkg::U_HOLD: begin
               cnt_r <= cnt_r + `CNT_W'(1);
               if (at(cnt_r, HOLD_CYCLES)) begin
                  req_r <= 1'b0;
                  state_r <= refclk_sw_pkg::U_WAIT;
               end
            end
            refclk_sw_pkg::U_WAIT: begin
               cnt_r <= '0;
               if (link.activeClock != startSel_r) begin
                  state_r <= keepPhase ? refclk_sw_pkg::U_RST
                                       : refclk_sw_pkg::U_IDLE;
                  rst_r <= keepPhase;
                  busy_r <= keepPhase;
               end
            end
            refclk_sw_pkg::U_RST: begin
               cnt_r <= cnt_r + `CNT_W'(1);
               if (at(cnt_r, `RESET_PULSE_CYCLES)) begin
                  rst_r <= 1'b0;
                  busy_r <= 1'b0;
                  state_r <= refclk_sw_pkg::U_IDLE;
               end
            end
         endcase
      end
   end

   // Outputs stay off until lock has held for a while
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pfd_r <= 1'b1;
         mode_r <= 1'b0;
         stable_r <= '0;
         ena_r <= 1'b0;
      end else begin
         pfd_r <= ~anyBad;
         mode_r <= manualOnlyCfg;
         if (!link.locked || busy_r || anyBad) begin
            stable_r <= '0;
            ena_r <= 1'b0;
         end else if (at(stable_r, LOCK_STABLE)) begin
            ena_r <= 1'b1;
         end else begin
            stable_r <= stable_r + `CNT_W'(1);
         end
      end
   end

   assign link.primaryRefClk = pRef_r;
   assign link.backupRefClk = bRef_r;
   assign link.switchReq = req_r;
   assign link.manualOnly = mode_r;
   assign link.pllReset = rst_r;
   assign link.pfdEna = pfd_r;
   assign outClkEna = ena_r;
   assign busy = busy_r;
endmodule
`default_nettype wire

// [tb/refclk_sw_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module refclk_sw_monitor #(
   parameter int LOSS_CYCLES = 20
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic primaryRefClk,
   input wire logic backupRefClk,
   input wire logic switchReq,
   input wire logic manualOnly,
   input wire logic pllReset,
   input wire logic pfdEna,
   input wire logic [1:0] clkBad,
   input wire logic activeClock,
   input wire logic locked
);
   int primIdle_r;
   int backIdle_r;
   int primFallAge_r;
   int backFallAge_r;
   int chgCnt_r;
   logic primPrev_r;
   logic backPrev_r;
   logic actPrev_r;
   logic reqPrev_r;
   wire reqRise = switchReq && !reqPrev_r;
   wire actChg = activeClock != actPrev_r;

   // Ages keep counting up without a ceiling, far beyond any bound used below
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         primIdle_r <= 0;
         backIdle_r <= 0;
         primFallAge_r <= 0;
         backFallAge_r <= 0;
         chgCnt_r <= 0;
         primPrev_r <= 1'b0;
         backPrev_r <= 1'b0;
         actPrev_r <= 1'b0;
         reqPrev_r <= 1'b0;
      end else begin
         primPrev_r <= primaryRefClk;
         backPrev_r <= backupRefClk;
         actPrev_r <= activeClock;
         reqPrev_r <= switchReq;
         primIdle_r <= (primaryRefClk != primPrev_r) ? 0 : primIdle_r + 1;
         backIdle_r <= (backupRefClk != backPrev_r) ? 0 : backIdle_r + 1;
         primFallAge_r <= (primPrev_r && !primaryRefClk) ? 0 :
                          primFallAge_r + 1;
         backFallAge_r <= (backPrev_r && !backupRefClk) ? 0 :
                          backFallAge_r + 1;
         chgCnt_r <= (reqRise || !manualOnly) ? 0 : chgCnt_r + int'(actChg);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_reset_state: assert property (
      $rose(arst_n) |-> !activeClock && clkBad == 2'b00 && !locked)
      else $error("state after reset wrong");
   chk_primary_loss: assert property (
      primIdle_r == LOSS_CYCLES + 4 |-> clkBad[0])
      else $error("primary loss flag missing");
   chk_backup_loss: assert property (
      backIdle_r == LOSS_CYCLES + 4 |-> clkBad[1])
      else $error("backup loss flag missing");
   chk_loss_not_early: assert property (
      $rose(clkBad[0]) |-> primIdle_r >= 3)
      else $error("primary loss flag while toggling");
   chk_auto_forward: assert property (
      // Only when the other input is still toggling
      $rose(clkBad[0]) && !activeClock && !manualOnly && !clkBad[1]
      && backIdle_r < LOSS_CYCLES / 2 |-> ##[1:20] activeClock)
      else $error("no automatic switch to backup");
   chk_auto_back: assert property (
      $rose(clkBad[1]) && activeClock && !manualOnly && !clkBad[0]
      && primIdle_r < LOSS_CYCLES / 2 |-> ##[1:20] !activeClock)
      else $error("no automatic switch back to primary");
   chk_manual_switch: assert property (
      $rose(switchReq) |-> ##[2:40] $changed(activeClock))
      else $error("request did not switch");
   chk_manual_flags: assert property (
      switchReq |-> clkBad == 2'b00)
      else $error("loss flag during manual switch");
   chk_join_edge: assert property (
      $changed(activeClock)
      |-> (activeClock ? backFallAge_r : primFallAge_r) <= 6)
      else $error("switch joined without target falling edge");
   chk_one_change: assert property (
      manualOnly |-> chgCnt_r <= 1)
      else $error("extra switch without request rise");
   chk_reset_unlock: assert property (
      pllReset [*2] |-> !locked)
      else $error("lock held during reset");

   cover property ($rose(clkBad[0]) ##[1:20] activeClock);
   cover property ($rose(switchReq) ##[2:40] $changed(activeClock));
   cover property ($rose(pllReset));
   cover property ($rose(locked) && pfdEna);
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "refclk_sw_cfg.svh"
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic primaryRun = 1'b1;
   logic backupRun = 1'b1;
   logic switchCmd = 1'b0;
   logic keepPhase = 1'b0;
   logic manualOnlyCfg = 1'b0;
   logic outClkEna;
   logic busy;
   logic gatedRef;
   logic [`OSC_W-1:0] oscCtrl;
   logic switching;
   int n_mismatch = 0;
   int tests_run = 0;
   int seed = 96;
   int expAct = 0;
   // Expected selection after each requested switch, oldest first
   int expQ[$];
   int i;
   int k;

   refclk_sw_if link();
   refclk_switchover #(.LOSS_CYCLES(6), .DRIFT_CYCLES(4))
      refclk_switchover_inst (.clk(clk), .arst_n(arst_n), .link(link),
      .gatedRef(gatedRef), .oscCtrl(oscCtrl), .switching(switching));
   // Equal reference rates keep loss detection valid
   switch_user_ctrl #(.PRIM_HALF(2), .BACK_HALF(2))
      switch_user_ctrl_inst (.clk(clk), .arst_n(arst_n), .link(link),
      .primaryRun(primaryRun), .backupRun(backupRun),
      .switchCmd(switchCmd), .keepPhase(keepPhase),
      .manualOnlyCfg(manualOnlyCfg), .outClkEna(outClkEna), .busy(busy));
   refclk_sw_monitor #(.LOSS_CYCLES(6)) refclk_sw_monitor_inst (
      .clk(clk), .arst_n(arst_n), .primaryRefClk(link.primaryRefClk),
      .backupRefClk(link.backupRefClk), .switchReq(link.switchReq),
      .manualOnly(link.manualOnly), .pllReset(link.pllReset),
      .pfdEna(link.pfdEna), .clkBad(link.clkBad),
      .activeClock(link.activeClock), .locked(link.locked));

   always #2 clk = ~clk;

   task automatic check(input string what, input logic [1:0] seen,
                        input logic [1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One switch request, then wait for the user end to go idle
   task automatic request(input logic kp);
      int w;
      logic sawSw;
      @(posedge clk);
      keepPhase <= kp;
      switchCmd <= 1'b1;
      @(posedge clk);
      switchCmd <= 1'b0;
      w = 0;
      sawSw = 1'b0;
      do begin
         @(posedge clk);
         #1;
         sawSw = sawSw | switching;
         w++;
      end while (busy !== 1'b0 && w < 300);
      check("busy", {1'b0, busy}, 2'b00);
      check("switching seen", {1'b0, sawSw}, 2'b01);
      check("switching done", {1'b0, switching}, 2'b00);
      expAct = 1 - expAct;
      expQ.push_back(expAct);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #40000;
      n_mismatch++;
      final_report();
   end

   initial begin
      idle(5);
      arst_n <= 1'b1;
      @(posedge clk);
      #1;
      check("active", {1'b0, link.activeClock}, 2'b00);
      check("bad", link.clkBad, 2'b00);
      idle(20);
      for (i = 0; i < 4; i++) begin
         request(1'($random(seed)));
         k = expQ.pop_front();
         check("active", {1'b0, link.activeClock}, 2'(k));
         check("bad", link.clkBad, 2'b00);
      end
      idle(40);
      check("active", {1'b0, link.activeClock}, 2'(expAct));
      primaryRun <= 1'b0;
      idle(40);
      check("bad", link.clkBad, 2'b01);
      check("active", {1'b0, link.activeClock}, 2'b01);
      primaryRun <= 1'b1;
      idle(20);
      check("bad", link.clkBad, 2'b00);
      backupRun <= 1'b0;
      idle(40);
      check("bad", link.clkBad, 2'b10);
      check("active", {1'b0, link.activeClock}, 2'b00);
      backupRun <= 1'b1;
      idle(20);
      // Target dead too: the switch must wait for it
      primaryRun <= 1'b0;
      backupRun <= 1'b0;
      idle(40);
      check("bad", link.clkBad, 2'b11);
      check("active", {1'b0, link.activeClock}, 2'b00);
      check("drift", {1'b0, oscCtrl < `OSC_NOMINAL}, 2'b01);
      backupRun <= 1'b1;
      idle(40);
      check("active", {1'b0, link.activeClock}, 2'b01);
      primaryRun <= 1'b1;
      expAct = 1;
      idle(20);
      manualOnlyCfg <= 1'b1;
      idle(2);
      backupRun <= 1'b0;
      idle(40);
      check("active", {1'b0, link.activeClock}, 2'b01);
      backupRun <= 1'b1;
      idle(20);
      request(1'b1);
      k = expQ.pop_front();
      check("active", {1'b0, link.activeClock}, 2'(k));
      @(posedge clk);
      manualOnlyCfg <= 1'b0;
      k = 0;
      while (link.locked !== 1'b1 && k < 1000) begin
         @(posedge clk);
         #1;
         k++;
      end
      check("locked", {1'b0, link.locked}, 2'b01);
      check("osc", {1'b0, oscCtrl == `OSC_NOMINAL}, 2'b01);
      k = 0;
      while (outClkEna !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      check("clock enable", {1'b0, outClkEna}, 2'b01);
      // Gated reference must toggle, neither stuck high nor low
      k = 0;
      repeat (8) begin
         @(posedge clk);
         #1;
         k += int'(gatedRef);
      end
      check("gated ref", {1'b0, k > 0 && k < 8}, 2'b01);
      final_report();
   end
endmodule
`default_nettype wire
